/* File: src/port_cfg_loader_consts.vh */
// constants for the eeprom to port configuration loader
// assumes 16-bit eeprom words, four ports, wishbone byte addresses
`ifndef PORT_CFG_LOADER_CONSTS_VH
`define PORT_CFG_LOADER_CONSTS_VH

// eeprom word addresses and load sequence
`define EE_PWR_BASE      8'h70
`define EE_RPLY_BASE     8'h78
`define EE_PMC_BASE      8'h80
`define EE_WORD_STEP     8'h02
`define EE_WORD_COUNT    4'd12
`define EE_LAST_IDX      4'd11

// default word values
`define DEF_PWR_WORD     16'h0004
`define DEF_RPLY_WORD    16'h0000
`define DEF_PMC_P0_WORD  16'h73a1
`define DEF_PMC_WORD     16'h33a1

// hardware defaults of the unmapped bits in each target register
`define HW_DEF_214       32'h00000000
`define HW_DEF_218       32'h00000000
`define HW_DEF_070       32'h00000000
`define HW_DEF_074       32'h00000000
`define HW_DEF_088       32'h00000000
`define HW_DEF_08C       32'h00000000

// wishbone register byte offsets
`define WB_CTRL_OFS      8'h00
`define WB_STAT_OFS      8'h04
`define WB_WORD_HI       2'b01
`define CTRL_RELOAD_BIT  0

`endif

/* File: src/port_cfg_map.v */
// one port's field scatter from three eeprom words into six config images
// assumes the words are held stable in flip-flops by the loader
`timescale 1ns/1ns
`default_nettype none
`include "port_cfg_loader_consts.vh"

module port_cfg_map (
    input  wire [15:0] pwr_i,
    input  wire [15:0] rply_i,
    input  wire [15:0] pmc_i,
    output wire [31:0] cfg_214_o,
    output wire [31:0] cfg_218_o,
    output wire [31:0] cfg_070_o,
    output wire [31:0] cfg_074_o,
    output wire [31:0] cfg_088_o,
    output wire [31:0] cfg_08c_o
);
    localparam [31:0] HW214 = `HW_DEF_214;
    localparam [31:0] HW218 = `HW_DEF_218;
    localparam [31:0] HW070 = `HW_DEF_070;
    localparam [31:0] HW074 = `HW_DEF_074;
    localparam [31:0] HW088 = `HW_DEF_088;
    localparam [31:0] HW08C = `HW_DEF_08C;

    // base power, data scale, pm state (gap at 12:10 keeps hw default)
    assign cfg_214_o = {HW214[31:15], pwr_i[11:10], HW214[12:10], pwr_i[9:0]};
    assign cfg_218_o = {HW218[31:1], pwr_i[15]};
    // 70h collects replay timeout from one word and vga enable from another
    assign cfg_070_o = {pmc_i[7], HW070[30:13], rply_i[12:0]};
    assign cfg_074_o = {HW074[31:15], pmc_i[6], pmc_i[5:0], HW074[7:0]};
    assign cfg_088_o = {pmc_i[15:8], HW088[23:0]};
    assign cfg_08c_o = {HW08C[31:26], rply_i[14:13], HW08C[23:0]};
endmodule

`default_nettype wire

/* File: src/eeprom_port_config_loader.v */
// eeprom to port configuration loader: fetches twelve words after reset and on each reload taken in ST_DONE, when ee_image_ok_i is high
// and scatters their fields into per-port config images
// assumes an eeprom reader that answers one word request with a one-cycle ack,
// and an image check done outside that raises ee_image_ok_i
//
// Implementation choices: the address map and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
`include "port_cfg_loader_consts.vh"

module eeprom_port_config_loader (
    input  wire         clk_i,
    input  wire         rst_i,
    // classic wishbone slave
    input  wire         wb_cyc_i,
    input  wire         wb_stb_i,
    input  wire         wb_we_i,
    input  wire [7:0]   wb_adr_i,
    input  wire [3:0]   wb_sel_i,
    input  wire [31:0]  wb_dat_i,
    output wire [31:0]  wb_dat_o,
    output wire         wb_ack_o,
    // eeprom word reader
    input  wire         ee_image_ok_i,
    output wire         ee_rd_o,
    output wire [7:0]   ee_addr_o,
    input  wire         ee_ack_i,
    input  wire [15:0]  ee_data_i,
    // per-port config images, port n at bits 32n+31:32n
    output wire [127:0] cfg_214_o,
    output wire [127:0] cfg_218_o,
    output wire [127:0] cfg_070_o,
    output wire [127:0] cfg_074_o,
    output wire [127:0] cfg_088_o,
    output wire [127:0] cfg_08c_o,
    output wire         load_done_o
);
    localparam [1:0] ST_START = 2'd0;
    localparam [1:0] ST_FETCH = 2'd1;
    localparam [1:0] ST_DONE  = 2'd2;

    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [3:0]  idx_q;
    reg  [3:0]  idx_d;
    reg         from_image_q;
    reg         from_image_d;
    reg  [15:0] word_q [0:11];
    reg         ack_q;
    reg  [31:0] dat_q;
    reg         reload_q;
    reg  [31:0] rd_d;

    wire        wb_hit;
    wire        wb_wr;
    wire [3:0]  wb_word;
    wire        wb_word_ok;
    wire        store;

    integer i;

    function [15:0] default_word;
        input [3:0] n;
        begin
            if (n < 4'd4) begin
                default_word = `DEF_PWR_WORD;
            end else if (n < 4'd8) begin
                default_word = `DEF_RPLY_WORD;
            end else if (n == 4'd8) begin
                default_word = `DEF_PMC_P0_WORD;
            end else begin
                default_word = `DEF_PMC_WORD;
            end
        end
    endfunction

    // wishbone: one wait state, answer comes one cycle after the request
    assign wb_hit     = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wb_wr      = wb_hit & wb_we_i;
    assign wb_word    = wb_adr_i[5:2];
    assign wb_word_ok = (wb_adr_i[7:6] == `WB_WORD_HI) && (wb_word < `EE_WORD_COUNT);
    assign wb_ack_o   = ack_q;
    assign wb_dat_o   = dat_q;

    always @* begin
        rd_d = 32'h00000000;
        if (wb_adr_i == `WB_STAT_OFS) begin
            rd_d = {25'h0000000, idx_q, from_image_q, state_q == ST_DONE,
                    state_q != ST_DONE};
        end else if (wb_word_ok) begin
            rd_d = {16'h0000, word_q[wb_word]};
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_q    <= 1'b0;
            dat_q    <= 32'h00000000;
            reload_q <= 1'b0;
        end else begin
            ack_q    <= wb_hit;
            reload_q <= 1'b0;
            if (wb_hit && !wb_we_i) begin
                dat_q <= rd_d;
            end
            // reload is a pulse; ignored while a load is still running
            if (wb_wr && wb_adr_i == `WB_CTRL_OFS && wb_sel_i[0] &&
                wb_dat_i[`CTRL_RELOAD_BIT]) begin
                reload_q <= 1'b1;
            end
        end
    end

    // load sequencer
    assign ee_rd_o   = (state_q == ST_FETCH);
    assign ee_addr_o = `EE_PWR_BASE + {3'b000, idx_q, 1'b0};
    assign store     = (state_q == ST_FETCH) && ee_ack_i;
    assign load_done_o = (state_q == ST_DONE);

    always @* begin
        state_d      = state_q;
        idx_d        = idx_q;
        from_image_d = from_image_q;
        case (state_q)
            ST_START: begin
                idx_d = 4'd0;
                from_image_d = ee_image_ok_i;
                // without a valid image the reset defaults stand
                state_d = ee_image_ok_i ? ST_FETCH : ST_DONE;
            end
            ST_FETCH: begin
                if (ee_ack_i) begin
                    if (idx_q == `EE_LAST_IDX) begin
                        state_d = ST_DONE;
                    end else begin
                        idx_d = idx_q + 4'd1;
                    end
                end
            end
            ST_DONE: begin
                if (reload_q) begin
                    state_d = ST_START;
                end
            end
            default: begin
                state_d = ST_START;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q      <= ST_START;
            idx_q        <= 4'd0;
            from_image_q <= 1'b0;
            for (i = 0; i < 12; i = i + 1) begin
                word_q[i] <= default_word(i[3:0]);
            end
        end else begin
            state_q      <= state_d;
            idx_q        <= idx_d;
            from_image_q <= from_image_d;
            if (state_q == ST_START) begin
                // a reload restarts from defaults so a bad image cannot leave stale words
                for (i = 0; i < 12; i = i + 1) begin
                    word_q[i] <= default_word(i[3:0]);
                end
            end else if (store) begin
                word_q[idx_q] <= ee_data_i;
            end
        end
    end

    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_port
            port_cfg_map u_map (
                .pwr_i     (word_q[p]),
                .rply_i    (word_q[p + 4]),
                .pmc_i     (word_q[p + 8]),
                .cfg_214_o (cfg_214_o[32*p +: 32]),
                .cfg_218_o (cfg_218_o[32*p +: 32]),
                .cfg_070_o (cfg_070_o[32*p +: 32]),
                .cfg_074_o (cfg_074_o[32*p +: 32]),
                .cfg_088_o (cfg_088_o[32*p +: 32]),
                .cfg_08c_o (cfg_08c_o[32*p +: 32])
            );
        end
    endgenerate
endmodule

`default_nettype wire

/* File: tb/ee_model.sv */
// eeprom word reader model: one word per request, random wait
// assumes the bench fills mem and seeds the generator
`timescale 1ns/1ns
`default_nettype none
module ee_model (
    input  wire logic        clk_i,
    input  wire logic        rd_i,
    input  wire logic [7:0]  addr_i,
    output wire logic        ack_o,
    output wire logic [15:0] data_o
);
    logic [15:0] mem [0:11];
    logic        ack_q = 1'b0;
    logic [15:0] dat_q = 16'h0000;
    int unsigned wait_q = 0;
    assign ack_o = ack_q;
    assign data_o = dat_q;
    always @(posedge clk_i) begin
        ack_q <= 1'b0;
        dat_q <= ~dat_q; // released bus inverts every cycle, so it holds the last word only every other cycle
        if (rd_i && !ack_q) begin
            if (wait_q == 0) begin
                ack_q <= 1'b1;
                dat_q <= mem[(addr_i - 8'h70) >> 1];
                wait_q <= $urandom_range(3);
            end else begin
                wait_q <= wait_q - 1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/loader_asserts.sv */
// field scatter and fetch order checks on the loader ports
// assumes bind onto the loader top
`timescale 1ns/1ns
`default_nettype none
module loader_asserts (
    input wire         clk_i,
    input wire         rst_i,
    input wire         ee_rd_o,
    input wire [7:0]   ee_addr_o,
    input wire         ee_ack_i,
    input wire [15:0]  ee_data_i,
    input wire [127:0] cfg_214_o,
    input wire [127:0] cfg_218_o,
    input wire [127:0] cfg_070_o,
    input wire [127:0] cfg_074_o,
    input wire [127:0] cfg_088_o,
    input wire [127:0] cfg_08c_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire tk = ee_rd_o && ee_ack_i;
    AST_PWR_LOW: assert property (tk && ee_addr_o == 8'h70 |=>
        cfg_214_o[9:0] == $past(ee_data_i[9:0])) else $error("base power wrong");
    AST_PM_STATE: assert property (tk && ee_addr_o == 8'h72 |=>
        cfg_214_o[46:45] == $past(ee_data_i[11:10])) else $error("pm state wrong");
    AST_SYS_ALLOC: assert property (tk && ee_addr_o == 8'h74 |=>
        cfg_218_o[64] == $past(ee_data_i[15])) else $error("system bit wrong");
    AST_REPLAY: assert property (tk && ee_addr_o == 8'h7e |=>
        cfg_070_o[108:96] == $past(ee_data_i[12:0])) else $error("replay wrong");
    AST_TS_CTL: assert property (tk && ee_addr_o == 8'h7a |=>
        cfg_08c_o[57:56] == $past(ee_data_i[14:13])) else $error("ts ctl wrong");
    AST_PM_CTL: assert property (tk && ee_addr_o == 8'h86 |=>
        cfg_074_o[110:104] == $past(ee_data_i[6:0])) else $error("pm ctl wrong");
    AST_VGA: assert property (tk && ee_addr_o == 8'h84 |=>
        cfg_070_o[95] == $past(ee_data_i[7])) else $error("vga bit wrong");
    AST_PHY_UP: assert property (tk && ee_addr_o == 8'h82 |=>
        cfg_088_o[63:56] == $past(ee_data_i[15:8])) else $error("phy byte wrong");
    AST_ORDER: assert property (tk && ee_addr_o != 8'h86 |=>
        ee_addr_o == $past(ee_addr_o) + 8'h02) else $error("fetch order wrong");
    AST_RD_HOLD: assert property (ee_rd_o && !ee_ack_i |=>
        ee_rd_o && $stable(ee_addr_o)) else $error("request dropped");
endmodule
bind eeprom_port_config_loader loader_asserts chk_i (.clk_i(clk_i), .rst_i(rst_i),
    .ee_rd_o(ee_rd_o), .ee_addr_o(ee_addr_o), .ee_ack_i(ee_ack_i), .ee_data_i(ee_data_i),
    .cfg_214_o(cfg_214_o), .cfg_218_o(cfg_218_o), .cfg_070_o(cfg_070_o),
    .cfg_074_o(cfg_074_o), .cfg_088_o(cfg_088_o), .cfg_08c_o(cfg_08c_o));
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the eeprom config loader
// assumes ee_model as the eeprom and the loader checker bound alongside
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, img = 0;
    logic [7:0] adr = 0;
    logic [3:0] sel = 4'hf;
    logic [31:0] dat = 0, rd;
    logic [15:0] w [0:11];
    wire ack, ee_rd, ee_ack, done;
    wire [7:0] ee_adr;
    wire [15:0] ee_dat;
    wire [31:0] wdo;
    wire [127:0] c214, c218, c070, c074, c088, c08c;
    int n_errors = 0, num_checks = 0, cycles = 0, reads = 0;
    always #20 clk = ~clk;
    eeprom_port_config_loader uut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wdo),
        .wb_ack_o(ack), .ee_image_ok_i(img), .ee_rd_o(ee_rd), .ee_addr_o(ee_adr),
        .ee_ack_i(ee_ack), .ee_data_i(ee_dat), .cfg_214_o(c214), .cfg_218_o(c218),
        .cfg_070_o(c070), .cfg_074_o(c074), .cfg_088_o(c088), .cfg_08c_o(c08c),
        .load_done_o(done));
    ee_model m (.clk_i(clk), .rd_i(ee_rd), .addr_i(ee_adr), .ack_o(ee_ack), .data_o(ee_dat));
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask
    always @(posedge clk) begin
        cycles++;
        if (ee_rd && ee_ack) reads++;
        if (cycles == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic wb(input logic w_e, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1; stb <= 1; we <= w_e; adr <= a; dat <= d;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        rd = wdo;
        cyc <= 0; stb <= 0;
        @(posedge clk);
    endtask
    task automatic load_and_check;
        repeat (3) @(posedge clk);
        while (done !== 1'b1) @(posedge clk);
        chk("reads", reads, img ? 12 : 0);
        for (int p = 0; p < 4; p++) begin
            chk("214", c214[32*p+:32], {17'h0, w[p][11:10], 3'h0, w[p][9:0]});
            chk("218", c218[32*p+:32], {31'h0, w[p][15]});
            chk("070", c070[32*p+:32], {w[p+8][7], 18'h0, w[p+4][12:0]});
            chk("074", c074[32*p+:32], {17'h0, w[p+8][6:0], 8'h0});
            chk("088", c088[32*p+:32], {w[p+8][15:8], 24'h0});
            chk("08c", c08c[32*p+:32], {6'h0, w[p+4][14:13], 24'h0});
        end
        // status: last index after a full fetch, source flag, done set, busy clear
        wb(0, 8'h04, 0);
        chk("stat", rd, {25'h0, img ? 4'hb : 4'h0, img, 2'b10});
    endtask
    initial begin
        void'($urandom(93793));
        w = '{16'h4, 16'h4, 16'h4, 16'h4, 0, 0, 0, 0, 16'h73a1, 16'h33a1, 16'h33a1, 16'h33a1};
        repeat (8) @(posedge clk);
        rst <= 0;
        load_and_check();
        for (int r = 0; r < 4; r++) begin
            for (int i = 0; i < 12; i++) begin
                w[i] = (r == 0) ? 16'hffff : 16'($urandom);
                m.mem[i] = w[i];
            end
            img <= 1;
            reads = 0;
            wb(1, 8'h00, 32'h1);
            // second reload lands mid-load and must be refused
            if (r == 1) wb(1, 8'h00, 32'h1);
            load_and_check();
            for (int i = 0; i < 12; i++) begin
                wb(0, 8'h40 + 8'(4 * i), 0);
                chk("raw", rd, {16'h0, w[i]});
            end
        end
        // reload with byte lane 0 off must not start a fetch
        sel <= 4'he;
        reads = 0;
        wb(1, 8'h00, 32'h1);
        sel <= 4'hf;
        repeat (4) @(posedge clk);
        chk("reload sel0 low", {31'h0, done}, 32'h1);
        chk("reload sel0 reads", reads, 0);
        // reload without a valid image must bring back every default word
        w = '{16'h4, 16'h4, 16'h4, 16'h4, 0, 0, 0, 0, 16'h73a1, 16'h33a1, 16'h33a1, 16'h33a1};
        img <= 0;
        reads = 0;
        wb(1, 8'h00, 32'h1);
        load_and_check();
        wb(0, 8'h30, 0);
        chk("unmapped", rd, 0);
        end_sim();
    end
endmodule
`default_nettype wire
